// ===== rtl/rspc_pkg.sv
// package: constants for the reset strap power configuration block
package rspc_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [3:0] RSPC_STATUS_ADDR = 4'h0;
   localparam logic [3:0] RSPC_CONTROL_ADDR = 4'h4;
   localparam logic [3:0] RSPC_ID_ADDR = 4'h8;
   // ---------------------------------------------------------------
   // status fields
   // ---------------------------------------------------------------
   localparam int RSPC_ST_PWR_SWITCH_EN = 0;
   localparam int RSPC_ST_GANGED = 1;
   localparam int RSPC_ST_ACTIVE_HIGH = 2;
   localparam int RSPC_ST_I2C_MODE = 3;
   localparam int RSPC_ST_ADDR_LO = 4;
   localparam int RSPC_ST_ADDR_HI = 5;
   localparam int RSPC_ST_CAPTURED = 6;
   localparam int RSPC_ST_OC_LO = 8;
   localparam int RSPC_ST_OC_HI = 11;
   localparam int RSPC_ST_PWR_LO = 12;
   localparam int RSPC_ST_PWR_HI = 15;
   // ---------------------------------------------------------------
   // control fields and reset value
   // ---------------------------------------------------------------
   localparam int RSPC_CT_REQ_LO = 0;
   localparam int RSPC_CT_REQ_HI = 3;
   localparam int RSPC_CT_SS_STAT_EN = 4;
   localparam int RSPC_CT_HS_STAT_EN = 5;
   localparam int RSPC_CT_WIDTH = 6;
   localparam logic [5:0] RSPC_CONTROL_RST = 6'h00;
   // identity value is arbitrary
   localparam logic [31:0] RSPC_ID_VALUE = 32'h5253_0001;
   // ---------------------------------------------------------------
   // axi responses
   // ---------------------------------------------------------------
   localparam logic [1:0] RSPC_RESP_OKAY = 2'h0;
   localparam logic [1:0] RSPC_RESP_SLVERR = 2'h2;
   // capture sequencer, one-hot
   typedef enum logic [1:0] {
      RSPC_ST_WAIT = 2'b01,
      RSPC_ST_RUN = 2'b10
   } rspc_state_t;
endpackage

// ===== rtl/rspc_top.sv
// module: strap capture, port power control and axi4-lite registers
// Summary of operation
// RULE1: a low power management strap enables power switching and over-current inputs, a high one disables both.
// RULE2: the power management strap level is captured at reset release and steers power switch control.
// RULE3: in smbus mode, slave address bit 1 is the level of the power management strap.
// RULE4: after reset, when enabled, the power management pin drives 1 while upstream is superspeed attached.
// RULE5: the board must strap power switching on when battery charging is used.
// RULE6: the polarity strap, captured at reset release, makes all four power outputs active low (0) or high (1).
// RULE7: the ganged strap, captured at reset release, selects per-port (0) or ganged (1) control when switching is on.
// RULE8: in smbus mode, slave address bit 2 is the level of the ganged strap.
// RULE9: the serial mode strap, captured at reset release, selects eeprom master (1) or smbus slave (0).
// RULE10: captured strap values stay fixed until the next reset, whatever the pins do later.
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
module rspc_top
   import rspc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // strap pins
   input wire logic power_mgmt_strap_n_i,
   output logic power_mgmt_strap_n_o,
   output logic power_mgmt_strap_n_oe_o,
   input wire logic ganged_strap_i,
   output logic ganged_strap_o,
   output logic ganged_strap_oe_o,
   input wire logic power_ctl_polarity_strap_i,
   input wire logic serial_mode_select_strap_i,
   // link status and power switch side
   input wire logic upstream_superspeed_connected_i,
   input wire logic upstream_highspeed_connected_i,
   input wire logic [3:0] overcur_n_i,
   output logic [3:0] port_power_enable_out_o,
   // configuration seen by the serial engine
   output logic smbus_mode_o,
   output logic [1:0] slave_addr_bits_o,
   // axi4-lite slave
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ---------------------------------------------------------------
   // strap capture
   // ---------------------------------------------------------------
   rspc_state_t state_reg, state_next;
   logic pwr_n_reg, pwr_n_next;
   logic gang_reg, gang_next;
   logic pol_reg, pol_next;
   logic ser_reg, ser_next;

   // capture at the first edge after release; async reset loads constants only
   always_comb begin
      state_next = state_reg;
      pwr_n_next = pwr_n_reg;
      gang_next = gang_reg;
      pol_next = pol_reg;
      ser_next = ser_reg;
      case (state_reg)
         RSPC_ST_WAIT: begin
            pwr_n_next = power_mgmt_strap_n_i; // RULE2
            gang_next = ganged_strap_i; // RULE7
            pol_next = power_ctl_polarity_strap_i; // RULE6
            ser_next = serial_mode_select_strap_i; // RULE9
            state_next = RSPC_ST_RUN;
         end
         RSPC_ST_RUN: begin
            // nothing reloads here, so later pin driving cannot disturb it
            state_next = RSPC_ST_RUN; // RULE10
         end
         default: begin
            state_next = RSPC_ST_WAIT;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= RSPC_ST_WAIT;
         pwr_n_reg <= 1'b1;
         gang_reg <= 1'b0;
         pol_reg <= 1'b1;
         ser_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         pwr_n_reg <= pwr_n_next;
         gang_reg <= gang_next;
         pol_reg <= pol_next;
         ser_reg <= ser_next;
      end
   end

   // ---------------------------------------------------------------
   // derived configuration
   // ---------------------------------------------------------------
   logic captured;
   logic switch_en;
   assign captured = (state_reg == RSPC_ST_RUN);
   assign switch_en = ~pwr_n_reg; // RULE1
   assign smbus_mode_o = captured & ~ser_reg; // RULE9
   // address bits only mean something in smbus mode
   assign slave_addr_bits_o = smbus_mode_o ? {gang_reg, pwr_n_reg} : 2'b00; // RULE3 RULE8

   // ---------------------------------------------------------------
   // control register and port power
   // ---------------------------------------------------------------
   logic [5:0] ctl_reg, ctl_next;
   logic [3:0] oc_reg, oc_next;
   logic [3:0] pwr_on_reg, pwr_on_next;
   logic [3:0] out_reg, out_next;
   logic wr_fire;
   logic [3:0] wr_addr_reg;
   logic [31:0] wr_data_reg;
   logic [3:0] wr_strb_reg;

   // over-current and switching only act with switching enabled
   always_comb begin
      oc_next = 4'h0;
      pwr_on_next = 4'hF;
      if (switch_en) begin // RULE1
         if (gang_reg) begin // RULE7
            oc_next = {4{~&overcur_n_i}};
            pwr_on_next = {4{ctl_reg[RSPC_CT_REQ_LO]}} & ~oc_next;
         end else begin
            oc_next = ~overcur_n_i;
            pwr_on_next = ctl_reg[RSPC_CT_REQ_HI:RSPC_CT_REQ_LO] & ~oc_next;
         end
      end
      // requests stay off until straps are known, outputs sit at 0 until then whatever the strapped polarity, polarity applied last
      if (!captured) begin
         pwr_on_next = 4'h0;
      end
      out_next = pol_reg ? pwr_on_next : ~pwr_on_next; // RULE6
   end

   // control writes honour byte lane 0, where every field lives
   always_comb begin
      ctl_next = ctl_reg;
      if (wr_fire && wr_addr_reg == RSPC_CONTROL_ADDR && wr_strb_reg[0]) begin
         ctl_next = wr_data_reg[RSPC_CT_WIDTH-1:0];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctl_reg <= RSPC_CONTROL_RST;
         oc_reg <= 4'h0;
         pwr_on_reg <= 4'h0;
         out_reg <= 4'h0;
      end else begin
         ctl_reg <= ctl_next;
         oc_reg <= oc_next;
         pwr_on_reg <= pwr_on_next;
         out_reg <= out_next;
      end
   end

   assign port_power_enable_out_o = out_reg;

   // ---------------------------------------------------------------
   // status outputs on the strap pins
   // ---------------------------------------------------------------
   logic ss_oe_reg, ss_oe_next, ss_val_reg, ss_val_next;
   logic hs_oe_reg, hs_oe_next, hs_val_reg, hs_val_next;

   // pins only drive once captured, so a strap is never fought
   always_comb begin
      ss_oe_next = captured & ctl_reg[RSPC_CT_SS_STAT_EN]; // RULE4
      ss_val_next = ss_oe_next & upstream_superspeed_connected_i; // RULE4
      hs_oe_next = captured & ctl_reg[RSPC_CT_HS_STAT_EN];
      hs_val_next = hs_oe_next & upstream_highspeed_connected_i;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ss_oe_reg <= 1'b0;
         ss_val_reg <= 1'b0;
         hs_oe_reg <= 1'b0;
         hs_val_reg <= 1'b0;
      end else begin
         ss_oe_reg <= ss_oe_next;
         ss_val_reg <= ss_val_next;
         hs_oe_reg <= hs_oe_next;
         hs_val_reg <= hs_val_next;
      end
   end

   assign power_mgmt_strap_n_oe_o = ss_oe_reg;
   assign power_mgmt_strap_n_o = ss_val_reg;
   assign ganged_strap_oe_o = hs_oe_reg;
   assign ganged_strap_o = hs_val_reg;

   // ---------------------------------------------------------------
   // axi4-lite write channel
   // ---------------------------------------------------------------
   logic aw_held_reg, aw_held_next;
   logic w_held_reg, w_held_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic [3:0] wr_addr_next;
   logic [31:0] wr_data_next;
   logic [3:0] wr_strb_next;

   // decode used by both channels
   function automatic logic addr_ok(input logic [3:0] a, input logic is_wr);
      addr_ok = (a == RSPC_CONTROL_ADDR) ||
         (!is_wr && (a == RSPC_STATUS_ADDR || a == RSPC_ID_ADDR));
   endfunction

   assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
   assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
   assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;

   // address and data are taken in either order, the write lands when both are in
   always_comb begin
      aw_held_next = aw_held_reg;
      w_held_next = w_held_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      wr_addr_next = wr_addr_reg;
      wr_data_next = wr_data_reg;
      wr_strb_next = wr_strb_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_held_next = 1'b1;
         wr_addr_next = {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_held_next = 1'b1;
         wr_data_next = s_axi_wdata;
         wr_strb_next = s_axi_wstrb;
      end
      if (wr_fire) begin
         aw_held_next = 1'b0;
         w_held_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = addr_ok(wr_addr_reg, 1'b1) ? RSPC_RESP_OKAY : RSPC_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RSPC_RESP_OKAY;
         wr_addr_reg <= 4'h0;
         wr_data_reg <= 32'h0000_0000;
         wr_strb_reg <= 4'h0;
      end else begin
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         wr_addr_reg <= wr_addr_next;
         wr_data_reg <= wr_data_next;
         wr_strb_reg <= wr_strb_next;
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   // ---------------------------------------------------------------
   // axi4-lite read channel
   // ---------------------------------------------------------------
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic [31:0] status_word;

   // status reports the captured straps and live port state
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[RSPC_ST_PWR_SWITCH_EN] = switch_en;
      status_word[RSPC_ST_GANGED] = gang_reg;
      status_word[RSPC_ST_ACTIVE_HIGH] = pol_reg;
      status_word[RSPC_ST_I2C_MODE] = ser_reg;
      status_word[RSPC_ST_ADDR_HI:RSPC_ST_ADDR_LO] = slave_addr_bits_o;
      status_word[RSPC_ST_CAPTURED] = captured;
      status_word[RSPC_ST_OC_HI:RSPC_ST_OC_LO] = oc_reg;
      status_word[RSPC_ST_PWR_HI:RSPC_ST_PWR_LO] = pwr_on_reg;
   end

   assign s_axi_arready = ~rvalid_reg;

   // one read in flight; data held until rready
   always_comb begin
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         rresp_next = addr_ok({s_axi_araddr[3:2], 2'b00}, 1'b0) ? RSPC_RESP_OKAY : RSPC_RESP_SLVERR;
         case ({s_axi_araddr[3:2], 2'b00})
            RSPC_STATUS_ADDR: rdata_next = status_word;
            RSPC_CONTROL_ADDR: rdata_next = {26'h000_0000, ctl_reg};
            RSPC_ID_ADDR: rdata_next = RSPC_ID_VALUE;
            default: rdata_next = 32'h0000_0000;
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RSPC_RESP_OKAY;
      end else begin
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

endmodule

// ===== sim/rspc_board.sv
// board model: strap resistors, port power switches and shared pins
module rspc_board (
   input wire logic [3:0] strap_i,
   input wire logic charging_i,
   input wire logic [3:0] fault_i,
   input wire logic pm_o_i,
   input wire logic pm_oe_i,
   input wire logic gang_o_i,
   input wire logic gang_oe_i,
   output logic pm_pin_o,
   output logic gang_pin_o,
   output logic pol_pin_o,
   output logic ser_pin_o,
   output logic [3:0] overcur_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // strap bits {serial, polarity, ganged, power mgmt}; a driven pin overrides its resistor
   // a charging board must keep power switching strapped on
   assign pm_pin_o = pm_oe_i ? pm_o_i : (strap_i[0] & ~charging_i);
   assign gang_pin_o = gang_oe_i ? gang_o_i : strap_i[1];
   assign pol_pin_o = strap_i[2];
   assign ser_pin_o = strap_i[3];
   // switches report faults as active-low levels, whether powered or not
   assign overcur_n_o = ~fault_i;
endmodule

// ===== sim/rspc_top_monitor.sv
// checker: strap capture, address bits, status pin and port power assertions
module rspc_top_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic power_mgmt_strap_n_i,
   input wire logic ganged_strap_i,
   input wire logic power_ctl_polarity_strap_i,
   input wire logic serial_mode_select_strap_i,
   input wire logic upstream_superspeed_connected_i,
   input wire logic [3:0] overcur_n_i,
   input wire logic power_mgmt_strap_n_o,
   input wire logic power_mgmt_strap_n_oe_o,
   input wire logic [3:0] port_power_enable_out_o,
   input wire logic smbus_mode_o,
   input wire logic [1:0] slave_addr_bits_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // helper: edges since release and own copy of the straps
   // ---------------------------------------------------------------
   logic [1:0] cnt_reg, cnt_next;
   logic [2:0] cap_reg, cap_next;
   // saturating count marks the capture edge; cap is {polarity, ganged, power mgmt}
   always_comb begin
      cnt_next = (cnt_reg == 2'd3) ? cnt_reg : cnt_reg + 2'd1;
      cap_next = (cnt_reg == 2'd0) ? {power_ctl_polarity_strap_i, ganged_strap_i, power_mgmt_strap_n_i} : cap_reg;
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_reg <= 2'd0;
         cap_reg <= 3'd0;
      end else begin
         cnt_reg <= cnt_next;
         cap_reg <= cap_next;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   property p_mode_cap;
      cnt_reg == 2'd1 |-> smbus_mode_o == !$past(serial_mode_select_strap_i);
   endproperty
   a_mode_cap: assert property (p_mode_cap) else $error("serial mode not from strap");
   property p_addr_cap;
      cnt_reg == 2'd1 && smbus_mode_o |-> slave_addr_bits_o == {$past(ganged_strap_i), $past(power_mgmt_strap_n_i)};
   endproperty
   a_addr_cap: assert property (p_addr_cap) else $error("address bits not from straps");
   property p_addr_zero;
      !smbus_mode_o |-> slave_addr_bits_o == 2'b00;
   endproperty
   a_addr_zero: assert property (p_addr_zero) else $error("address bits outside smbus mode");
   property p_hold;
      cnt_reg == 2'd3 |-> $stable(smbus_mode_o) && $stable(slave_addr_bits_o);
   endproperty
   a_hold: assert property (p_hold) else $error("captured config changed");
   property p_ss_flag;
      power_mgmt_strap_n_oe_o |-> power_mgmt_strap_n_o == $past(upstream_superspeed_connected_i);
   endproperty
   a_ss_flag: assert property (p_ss_flag) else $error("superspeed flag wrong");
   property p_ss_late;
      power_mgmt_strap_n_oe_o |-> cnt_reg >= 2'd2;
   endproperty
   a_ss_late: assert property (p_ss_late) else $error("pin driven before capture");
   property p_sw_off;
      cnt_reg == 2'd3 && cap_reg[0] |-> port_power_enable_out_o == {4{cap_reg[2]}};
   endproperty
   a_sw_off: assert property (p_sw_off) else $error("ports not always on");
   property p_gang_oc;
      cnt_reg == 2'd3 && !cap_reg[0] && cap_reg[1] && $past(overcur_n_i) != 4'hf
         |-> port_power_enable_out_o == {4{!cap_reg[2]}};
   endproperty
   a_gang_oc: assert property (p_gang_oc) else $error("ganged fault left power on");
   property p_port_oc;
      cnt_reg == 2'd3 && !cap_reg[0] && !cap_reg[1]
         |-> ((port_power_enable_out_o ^ {4{!cap_reg[2]}}) & ~$past(overcur_n_i)) == 4'h0;
   endproperty
   a_port_oc: assert property (p_port_oc) else $error("faulted port left on");
   c_smbus: cover property (cnt_reg == 2'd3 && smbus_mode_o);
   c_flag: cover property (power_mgmt_strap_n_oe_o && power_mgmt_strap_n_o);
   c_gang: cover property (cnt_reg == 2'd3 && !cap_reg[0] && cap_reg[1] && overcur_n_i != 4'hf);
endmodule

bind rspc_top rspc_top_monitor i_rspc_top_monitor (.clk_i(clk_i), .rst_i(rst_i),
   .power_mgmt_strap_n_i(power_mgmt_strap_n_i), .ganged_strap_i(ganged_strap_i),
   .power_ctl_polarity_strap_i(power_ctl_polarity_strap_i), .serial_mode_select_strap_i(serial_mode_select_strap_i),
   .upstream_superspeed_connected_i(upstream_superspeed_connected_i), .overcur_n_i(overcur_n_i),
   .power_mgmt_strap_n_o(power_mgmt_strap_n_o), .power_mgmt_strap_n_oe_o(power_mgmt_strap_n_oe_o),
   .port_power_enable_out_o(port_power_enable_out_o), .smbus_mode_o(smbus_mode_o),
   .slave_addr_bits_o(slave_addr_bits_o));

// ===== sim/testbench.sv
// testbench: strap configurations, port power, status pin and register access
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import rspc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] strap = 4'h4, fault = 4'h0, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
   logic ss_up = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic [3:0] cfg [4] = '{4'h4, 4'h2, 4'h3, 4'hE};
   logic [3:0] req [2] = '{4'h5, 4'hA};
   logic [3:0] flt [2] = '{4'h0, 4'h4};
   logic pm_pin, gang_pin, pol_pin, ser_pin, pm_o, pm_oe, gang_o, gang_oe, smbus_mode_o;
   logic [3:0] oc_n, port_pwr;
   logic [1:0] addr_bits, s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int miscompares = 0, comparisons = 0, cycles = 0;
   // ---------------------------------------------------------------
   // design, board and clock
   // ---------------------------------------------------------------
   rspc_board i_rspc_board (.strap_i(strap), .charging_i(1'b0), .fault_i(fault), .pm_o_i(pm_o), .pm_oe_i(pm_oe),
      .gang_o_i(gang_o), .gang_oe_i(gang_oe), .pm_pin_o(pm_pin), .gang_pin_o(gang_pin), .pol_pin_o(pol_pin),
      .ser_pin_o(ser_pin), .overcur_n_o(oc_n));
   rspc_top i_rspc_top (.clk_i(clk_i), .rst_i(rst_i), .power_mgmt_strap_n_i(pm_pin), .power_mgmt_strap_n_o(pm_o),
      .power_mgmt_strap_n_oe_o(pm_oe), .ganged_strap_i(gang_pin), .ganged_strap_o(gang_o), .ganged_strap_oe_o(gang_oe),
      .power_ctl_polarity_strap_i(pol_pin), .serial_mode_select_strap_i(ser_pin),
      .upstream_superspeed_connected_i(ss_up), .upstream_highspeed_connected_i(ss_up), .overcur_n_i(oc_n),
      .port_power_enable_out_o(port_pwr), .smbus_mode_o(smbus_mode_o), .slave_addr_bits_o(addr_bits),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic conclude();
      if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // a hang counts as a mismatch
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         miscompares = miscompares + 1;
         conclude();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons = comparisons + 1;
      if (g !== e) begin
         miscompares = miscompares + 1;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // straps are bits {serial, polarity, ganged, power mgmt}, sampled as reset lets go
   task automatic boot(input logic [3:0] s);
      @(posedge clk_i);
      strap <= s;
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask
   // ready is sampled at the negedge before the edge that takes it, so no race with the design
   task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw, w, ta, tw;
      @(posedge clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw = 1'b0;
      w = 1'b0;
      while (!(aw && w)) begin
         @(negedge clk_i);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         @(posedge clk_i);
         if (ta) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (tw) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      ta = 1'b0;
      while (!ta) begin
         @(negedge clk_i);
         ta = s_axi_bvalid;
         if (ta) chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
         @(posedge clk_i);
      end
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
      logic tk;
      @(posedge clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      tk = 1'b0;
      while (!tk) begin
         @(negedge clk_i);
         tk = s_axi_arready;
         @(posedge clk_i);
      end
      s_axi_arvalid <= 1'b0;
      tk = 1'b0;
      while (!tk) begin
         @(negedge clk_i);
         tk = s_axi_rvalid;
         if (tk) chk("rdata", e, s_axi_rdata);
         if (tk) chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
         @(posedge clk_i);
      end
      s_axi_rready <= 1'b0;
   endtask
   // status with control cleared and no faults
   function automatic logic [31:0] stx(input logic [3:0] s);
      return {16'h0000, {4{s[0]}}, 4'h0, 2'b01, (s[3] ? 2'b00 : s[1:0]), s[3:1], ~s[0]};
   endfunction
   function automatic logic [3:0] pexp(input logic [3:0] s, input logic [3:0] r, input logic [3:0] f);
      logic [3:0] l;
      if (s[0]) l = 4'hF;
      else if (s[1]) l = (r[0] && f == 4'h0) ? 4'hF : 4'h0;
      else l = r & ~f;
      return s[2] ? l : ~l;
   endfunction
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      boot(4'h4);
      axr(RSPC_ID_ADDR, RSPC_ID_VALUE, RSPC_RESP_OKAY);
      axr(4'hC, 32'h0, RSPC_RESP_SLVERR);
      axw(RSPC_STATUS_ADDR, 32'h0000_000F, RSPC_RESP_SLVERR);
      // a write without byte lane 0 is accepted but must leave control untouched
      wstrb <= 4'he;
      axw(RSPC_CONTROL_ADDR, 32'h0000_003F, RSPC_RESP_OKAY);
      wstrb <= 4'hf;
      axr(RSPC_CONTROL_ADDR, 32'h0000_0000, RSPC_RESP_OKAY);
      foreach (cfg[k]) begin
         boot(cfg[k]);
         axr(RSPC_STATUS_ADDR, stx(cfg[k]), RSPC_RESP_OKAY);
         chk("smbus_mode_o", {31'h0, ~cfg[k][3]}, {31'h0, smbus_mode_o});
         foreach (req[i]) foreach (flt[j]) begin
            axw(RSPC_CONTROL_ADDR, {28'h0, req[i]}, RSPC_RESP_OKAY);
            @(posedge clk_i);
            fault <= flt[j];
            repeat (3) @(negedge clk_i);
            chk("port_pwr", {28'h0, pexp(cfg[k], req[i], flt[j])}, {28'h0, port_pwr});
         end
         @(posedge clk_i);
         fault <= 4'h0;
         ss_up <= 1'b1;
         axw(RSPC_CONTROL_ADDR, 32'h0000_0030, RSPC_RESP_OKAY);
         repeat (3) @(negedge clk_i);
         chk("pm_flag", 32'h3, {30'h0, pm_oe, pm_o});
         chk("gang_flag", 32'h3, {30'h0, gang_oe, gang_o});
         @(posedge clk_i);
         ss_up <= 1'b0;
         strap <= ~cfg[k];
         repeat (3) @(negedge clk_i);
         chk("pm_flag", 32'h2, {30'h0, pm_oe, pm_o});
         chk("gang_flag", 32'h2, {30'h0, gang_oe, gang_o});
         axr(RSPC_STATUS_ADDR, stx(cfg[k]), RSPC_RESP_OKAY);
      end
      conclude();
   end
endmodule
